// ===== rtl/rfp_consts.svh
`ifndef RFP_CONSTS_SVH
`define RFP_CONSTS_SVH

// Register indices on the register port (word registers)
`define RFP_IDX_CTL 3'h0
`define RFP_IDX_CSR 3'h1
`define RFP_IDX_CNT 3'h2
`define RFP_IDX_COR 3'h3
`define RFP_IDX_PAR 3'h4

// Write passwords carried in the upper byte of a word write
`define RFP_KEY_CTL 8'h5A
`define RFP_KEY_CSR 8'hA5
`define RFP_KEY_CNT 8'h69
`define RFP_KEY_COR 8'h96

// Power-on reset values
`define RFP_RST_CTL 8'h00
`define RFP_RST_CSR 8'h00
`define RFP_RST_CNT 8'h00
`define RFP_RST_COR 8'hFF
`define RFP_RST_PAR 5'h00

// Refresh control fields
`define RFP_CTL_REFRESH_EN 7
`define RFP_CTL_SELF_MODE 6
`define RFP_CTL_WAIT_HI 5
`define RFP_CTL_WAIT_LO 4

// Timer control/status fields
`define RFP_CSR_MATCH_FLAG 7
`define RFP_CSR_IRQ_EN 6
`define RFP_CSR_CKS_HI 5
`define RFP_CSR_CKS_LO 3

// Parity control fields (positions within the 16-bit word)
`define RFP_PAR_ERR_FLAG 15
`define RFP_PAR_FORCE 14
`define RFP_PAR_ODD 13
`define RFP_PAR_SPACE_HI 12
`define RFP_PAR_SPACE_LO 11

// Prescaler width and the low-bit masks that give each division
`define RFP_PRE_W 12
`define RFP_MASK_DIV2 12'h001
`define RFP_MASK_DIV8 12'h007
`define RFP_MASK_DIV32 12'h01F
`define RFP_MASK_DIV128 12'h07F
`define RFP_MASK_DIV512 12'h1FF
`define RFP_MASK_DIV2048 12'h7FF
`define RFP_MASK_DIV4096 12'hFFF

`endif

// ===== rtl/rfp_pkg.sv
package rfp_pkg;

    // Counter clock selection
    typedef enum logic [2:0] {
        RFP_CKS_STOP = 3'h0,
        RFP_CKS_D2 = 3'h1,
        RFP_CKS_D8 = 3'h2,
        RFP_CKS_D32 = 3'h3,
        RFP_CKS_D128 = 3'h4,
        RFP_CKS_D512 = 3'h5,
        RFP_CKS_D2048 = 3'h6,
        RFP_CKS_D4096 = 3'h7
    } rfp_cks_type;

    // Parity space selection
    typedef enum logic [1:0] {
        RFP_SPC_NONE = 2'h0,
        RFP_SPC_DRAM = 2'h1,
        RFP_SPC_DRAM_A2 = 2'h2,
        RFP_SPC_RSVD = 2'h3
    } rfp_space_type;

    // One CPU access to the register file
    typedef struct packed {
        logic [2:0] sel;    // Register index
        logic wr;           // Write strobe, one cycle
        logic rd;           // Read strobe, one cycle
        logic word;         // 1 word access, 0 byte access
        logic hi;           // Byte access to upper lane
        logic [15:0] wdata; // Write data
    } rfp_reg_req_type;

    // One external memory data transfer, as seen by the parity unit
    typedef struct packed {
        logic dram;         // Access to DRAM space
        logic area2;        // Access to area 2
        logic wide;         // 16-bit bus width
        logic wr_active;    // Data being driven out
        logic rd_strobe;    // Read data valid this cycle
        logic [15:0] data;  // Data on the bus
    } rfp_mem_xfer_type;

endpackage

// ===== rtl/rfp_refresh_parity.sv
`timescale 1ns/10ps
`include "rfp_consts.svh"
// Function
// - Interrupt only when enable set and flag set
// - Select field picks stop or seven divided clocks
// - Counter runs on selection, holds when stopped
// - Equal compare clears counter and sets flag
// - Match requests refresh when refresh enabled and self-refresh mode off
// - Match raises interrupt when interrupt enabled
// - Counter and period upper bytes read zero
// - Counter cleared by power-on reset and by compare match
// - Period loads all ones at power-on reset
// - Parity error flag cleared by read-then-write-zero
// - Force bit drives both parity pins high
// - Polarity bit selects even or odd parity
// - Space field selects none, DRAM, DRAM plus area2
// - Parity control resets only at power-on, reserved zero
// - Protected registers written by word only
// - Control key 5A, status key A5
// - Counter key 69, period key 96
// - Wrong key leaves register unchanged
// - Protected reads free, upper byte zero
// - Refresh disabled means plain interval timer
// - Match flag cleared only by read-then-write-zero
module rfp_refresh_parity (
    input wire logic CORE_CLK, // System clock, 25 MHz
    input wire logic NRST, // Power-on reset, active low
    input wire rfp_pkg::rfp_reg_req_type REG_REQ, // CPU register access
    output logic [15:0] REG_RDATA, // Read data, one cycle after strobe
    output logic MATCH_INTERRUPT, // Compare match interrupt level
    output logic REFRESH_REQ, // CBR refresh request pulse
    output logic SELF_REFRESH, // Self-refresh mode level
    output logic [1:0] REFRESH_WAIT, // Wait states during CBR refresh
    input wire rfp_pkg::rfp_mem_xfer_type MEM_XFER, // External data transfer
    input wire logic PARITY_PIN_UPPER_IN, // Upper parity pin level
    input wire logic PARITY_PIN_LOWER_IN, // Lower parity pin level
    output logic PARITY_PIN_UPPER_OUT, // Upper parity pin drive value
    output logic PARITY_PIN_UPPER_OE, // Upper parity pin enable
    output logic PARITY_PIN_LOWER_OUT, // Lower parity pin drive value
    output logic PARITY_PIN_LOWER_OE // Lower parity pin enable
);

    // Stored registers
    logic [7:0] refresh_ctrl_reg; // Refresh control, low byte
    logic match_flag_reg; // Compare match flag
    logic match_irq_enable_reg; // Interrupt enable
    rfp_pkg::rfp_cks_type count_clock_select_reg; // Counter clock select
    logic [7:0] refresh_counter_reg; // 8-bit up-counter
    logic [7:0] refresh_period_reg; // Period constant
    logic parity_error_flag_reg; // Latched parity error
    logic parity_force_high_reg; // Force parity pins high
    logic parity_odd_select_reg; // Odd parity when set
    rfp_pkg::rfp_space_type parity_space_reg; // Checked spaces
    logic [`RFP_PRE_W-1:0] prescale_reg; // Free-running prescaler
    logic match_armed_reg; // Match flag was read while set
    logic perr_armed_reg; // Parity flag was read while set

    // Decoded access terms
    logic [7:0] key; // Upper byte of a word write
    logic word_wr; // Word write of any register
    logic wr_ctl, wr_csr, wr_cnt, wr_cor; // Accepted protected writes
    logic wr_par; // Write reaching parity control fields
    logic [`RFP_PRE_W-1:0] div_mask; // Prescaler mask for selection
    logic count_tick; // Counter advance enable
    logic match_evt; // Counter equals period
    logic refresh_enable; // Refresh enable bit
    logic space_hit; // Current transfer is in a checked space
    logic [1:0] par_gen; // Computed parity per byte lane
    logic [1:0] lane_used; // Lanes carrying data
    logic [1:0] lane_err; // Mismatch per lane
    logic [1:0] pin_in; // Parity pins, lane order
    logic [15:0] rd_word; // Selected register as a word
    logic csr_clear_req; // Status write asking to clear the flag
    logic par_clear_req; // Parity write asking to clear the flag

    assign key = REG_REQ.wdata[15:8];
    assign word_wr = REG_REQ.wr && REG_REQ.word;
    // Byte writes never reach protected registers
    // Each register accepts only its own password
    assign wr_ctl = word_wr && (REG_REQ.sel == `RFP_IDX_CTL) && (key == `RFP_KEY_CTL);
    assign wr_csr = word_wr && (REG_REQ.sel == `RFP_IDX_CSR) && (key == `RFP_KEY_CSR);
    assign wr_cnt = word_wr && (REG_REQ.sel == `RFP_IDX_CNT) && (key == `RFP_KEY_CNT);
    assign wr_cor = word_wr && (REG_REQ.sel == `RFP_IDX_COR) && (key == `RFP_KEY_COR);
    // Parity control is unprotected; a word or an upper-lane byte carries its fields
    assign wr_par = REG_REQ.wr && (REG_REQ.sel == `RFP_IDX_PAR)
                    && (REG_REQ.word || REG_REQ.hi);
    assign refresh_enable = refresh_ctrl_reg[`RFP_CTL_REFRESH_EN];
    assign csr_clear_req = wr_csr && !REG_REQ.wdata[`RFP_CSR_MATCH_FLAG];
    assign par_clear_req = wr_par && !REG_REQ.wdata[`RFP_PAR_ERR_FLAG];

    // Division select; the counter steps when the masked prescaler bits are all ones
    always_comb begin
        case (count_clock_select_reg)
            rfp_pkg::RFP_CKS_D2: div_mask = `RFP_MASK_DIV2;
            rfp_pkg::RFP_CKS_D8: div_mask = `RFP_MASK_DIV8;
            rfp_pkg::RFP_CKS_D32: div_mask = `RFP_MASK_DIV32;
            rfp_pkg::RFP_CKS_D128: div_mask = `RFP_MASK_DIV128;
            rfp_pkg::RFP_CKS_D512: div_mask = `RFP_MASK_DIV512;
            rfp_pkg::RFP_CKS_D2048: div_mask = `RFP_MASK_DIV2048;
            rfp_pkg::RFP_CKS_D4096: div_mask = `RFP_MASK_DIV4096;
            default: div_mask = `RFP_MASK_DIV2;
        endcase
    end

    // Stop selection blocks every tick
    assign count_tick = (count_clock_select_reg != rfp_pkg::RFP_CKS_STOP)
                        && ((prescale_reg & div_mask) == div_mask);
    // Compare runs every cycle, independent of the tick
    assign match_evt = (refresh_counter_reg == refresh_period_reg);

    // Free-running prescaler; shared by all divisions so a change of selection
    // takes effect at once without restarting a divider
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + {{(`RFP_PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // Refresh control register; only power-on reset clears it
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            refresh_ctrl_reg <= `RFP_RST_CTL;
        end else if (wr_ctl) begin
            refresh_ctrl_reg <= {REG_REQ.wdata[7:4], 4'h0};
        end
    end

    // Timer control fields
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            match_irq_enable_reg <= 1'(`RFP_RST_CSR >> `RFP_CSR_IRQ_EN);
            count_clock_select_reg <= rfp_pkg::RFP_CKS_STOP;
        end else if (wr_csr) begin
            match_irq_enable_reg <= REG_REQ.wdata[`RFP_CSR_IRQ_EN];
            count_clock_select_reg <=
                rfp_pkg::rfp_cks_type'(REG_REQ.wdata[`RFP_CSR_CKS_HI:`RFP_CSR_CKS_LO]);
        end
    end

    // Match flag; a match in the clearing cycle wins over the clear
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            match_flag_reg <= 1'b0;
        end else if (match_evt) begin
            match_flag_reg <= 1'b1;
        end else if (csr_clear_req && match_armed_reg) begin
            match_flag_reg <= 1'b0;
        end
    end

    // Read of the status register while the flag is set arms the clear
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            match_armed_reg <= 1'b0;
        end else if (!match_flag_reg) begin
            match_armed_reg <= 1'b0;
        end else if (REG_REQ.rd && (REG_REQ.sel == `RFP_IDX_CSR)
                     && (REG_REQ.word || !REG_REQ.hi)) begin
            match_armed_reg <= 1'b1;
        end
    end

    // Counter: write first, then clear on match, then count
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            refresh_counter_reg <= `RFP_RST_CNT;
        end else if (wr_cnt) begin
            refresh_counter_reg <= REG_REQ.wdata[7:0];
        end else if (match_evt) begin
            refresh_counter_reg <= `RFP_RST_CNT;
        end else if (count_tick) begin
            refresh_counter_reg <= refresh_counter_reg + 8'h01;
        end
    end

    // Period constant
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            refresh_period_reg <= `RFP_RST_COR;
        end else if (wr_cor) begin
            refresh_period_reg <= REG_REQ.wdata[7:0];
        end
    end

    // Refresh request pulse; self-refresh mode suppresses CBR requests, and with
    // refresh disabled the counter is only an interval timer
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            REFRESH_REQ <= 1'b0;
        end else begin
            REFRESH_REQ <= match_evt && refresh_enable && !refresh_ctrl_reg[`RFP_CTL_SELF_MODE];
        end
    end

    // Refresh mode and wait-state outputs follow the control register
    assign SELF_REFRESH = refresh_enable && refresh_ctrl_reg[`RFP_CTL_SELF_MODE];
    assign REFRESH_WAIT = refresh_ctrl_reg[`RFP_CTL_WAIT_HI:`RFP_CTL_WAIT_LO];

    // Interrupt is a level held while flag and enable are both set
    assign MATCH_INTERRUPT = match_flag_reg && match_irq_enable_reg;

    // Parity control fields; only power-on reset clears them
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            {parity_force_high_reg, parity_odd_select_reg} <= 2'(`RFP_RST_PAR >> 2);
            parity_space_reg <= rfp_pkg::RFP_SPC_NONE;
        end else if (wr_par) begin
            parity_force_high_reg <= REG_REQ.wdata[`RFP_PAR_FORCE];
            parity_odd_select_reg <= REG_REQ.wdata[`RFP_PAR_ODD];
            parity_space_reg <=
                rfp_pkg::rfp_space_type'(REG_REQ.wdata[`RFP_PAR_SPACE_HI:`RFP_PAR_SPACE_LO]);
        end
    end

    // Space decode; the reserved code checks nothing
    always_comb begin
        case (parity_space_reg)
            rfp_pkg::RFP_SPC_DRAM: space_hit = MEM_XFER.dram;
            rfp_pkg::RFP_SPC_DRAM_A2: space_hit = MEM_XFER.dram || MEM_XFER.area2;
            default: space_hit = 1'b0;
        endcase
    end

    assign lane_used = {MEM_XFER.wide, 1'b1};
    assign pin_in = {PARITY_PIN_UPPER_IN, PARITY_PIN_LOWER_IN};

    // Per byte lane: parity bit and check against the received pin
    genvar lane;
    generate
        for (lane = 0; lane < 2; lane++) begin : g_lane
            // Even: bit makes the nine-bit sum even; odd inverts it
            assign par_gen[lane] = (^MEM_XFER.data[lane*8 +: 8]) ^ parity_odd_select_reg;
            assign lane_err[lane] = lane_used[lane] && (pin_in[lane] != par_gen[lane]);
        end
    endgenerate

    // Parity error flag; a new error wins over a clear in the same cycle
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            parity_error_flag_reg <= 1'b0;
        end else if (MEM_XFER.rd_strobe && space_hit && (|lane_err)) begin
            parity_error_flag_reg <= 1'b1;
        end else if (par_clear_req && perr_armed_reg) begin
            parity_error_flag_reg <= 1'b0;
        end
    end

    // Read of the parity register while the error flag is set arms its clear
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            perr_armed_reg <= 1'b0;
        end else if (!parity_error_flag_reg) begin
            perr_armed_reg <= 1'b0;
        end else if (REG_REQ.rd && (REG_REQ.sel == `RFP_IDX_PAR)
                     && (REG_REQ.word || REG_REQ.hi)) begin
            perr_armed_reg <= 1'b1;
        end
    end

    // Parity pin drive, registered; pins are released outside checked writes
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            PARITY_PIN_UPPER_OUT <= 1'b0;
            PARITY_PIN_LOWER_OUT <= 1'b0;
            PARITY_PIN_UPPER_OE <= 1'b0;
            PARITY_PIN_LOWER_OE <= 1'b0;
        end else begin
            // Forced high lets software test the checker
            PARITY_PIN_UPPER_OUT <= parity_force_high_reg || par_gen[1];
            PARITY_PIN_LOWER_OUT <= parity_force_high_reg || par_gen[0];
            PARITY_PIN_UPPER_OE <= MEM_XFER.wr_active && space_hit && MEM_XFER.wide;
            PARITY_PIN_LOWER_OE <= MEM_XFER.wr_active && space_hit;
        end
    end

    // Register readback; upper bytes of the timer registers read zero
    always_comb begin
        case (REG_REQ.sel)
            `RFP_IDX_CTL: rd_word = {8'h00, refresh_ctrl_reg};
            `RFP_IDX_CSR: rd_word = {8'h00, match_flag_reg, match_irq_enable_reg,
                                     count_clock_select_reg, 3'h0};
            `RFP_IDX_CNT: rd_word = {8'h00, refresh_counter_reg};
            `RFP_IDX_COR: rd_word = {8'h00, refresh_period_reg};
            `RFP_IDX_PAR: rd_word = {parity_error_flag_reg, parity_force_high_reg,
                                     parity_odd_select_reg, parity_space_reg,
                                     11'h000};
            default: rd_word = 16'h0000;
        endcase
    end

    // Read data registered; a byte read returns its lane and zeros elsewhere
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_REQ.rd) begin
            if (REG_REQ.word) begin
                REG_RDATA <= rd_word;
            end else if (REG_REQ.hi) begin
                REG_RDATA <= {rd_word[15:8], 8'h00};
            end else begin
                REG_RDATA <= {8'h00, rd_word[7:0]};
            end
        end
    end

    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_match_seen;
        match_evt && !wr_cnt;
    endsequence
    sequence s_flag_and_zero;
        (refresh_counter_reg == 8'h00) && match_flag_reg;
    endsequence

    irq_needs_enable_a: assert property (
        MATCH_INTERRUPT |-> match_irq_enable_reg && match_flag_reg)
        else $error("interrupt without enable and flag");
    stop_holds_a: assert property (
        (count_clock_select_reg == rfp_pkg::RFP_CKS_STOP) && !wr_cnt && !match_evt
        |=> $stable(refresh_counter_reg))
        else $error("counter moved while stopped");
    div2_counts_a: assert property (
        (count_clock_select_reg == rfp_pkg::RFP_CKS_D2)
        && !wr_cnt && !match_evt && !wr_csr && prescale_reg[0]
        |=> refresh_counter_reg == $past(refresh_counter_reg) + 8'h01)
        else $error("divide by two did not count");
    match_clears_a: assert property (s_match_seen |=> s_flag_and_zero)
        else $error("match did not clear counter and set flag");
    refresh_pulse_a: assert property (
        s_match_seen ##0 (refresh_enable && !refresh_ctrl_reg[`RFP_CTL_SELF_MODE])
        |=> REFRESH_REQ)
        else $error("missing refresh request");
    no_refresh_a: assert property (!$past(refresh_enable) |-> !REFRESH_REQ)
        else $error("refresh with refresh disabled");
    irq_on_match_a: assert property (
        s_match_seen ##0 (match_irq_enable_reg && !wr_csr) |=> MATCH_INTERRUPT)
        else $error("match did not raise interrupt");
    byte_wr_ignored_a: assert property (
        REG_REQ.wr && !REG_REQ.word && (REG_REQ.sel == `RFP_IDX_COR)
        |=> $stable(refresh_period_reg))
        else $error("byte write changed period");
    bad_key_a: assert property (
        word_wr && (REG_REQ.sel == `RFP_IDX_CTL) && (key != `RFP_KEY_CTL)
        |=> $stable(refresh_ctrl_reg))
        else $error("wrong key changed control");
    good_key_a: assert property (
        wr_cor |=> refresh_period_reg == $past(REG_REQ.wdata[7:0]))
        else $error("period write lost");
    upper_zero_a: assert property (
        REG_REQ.rd && REG_REQ.word && (REG_REQ.sel != `RFP_IDX_PAR)
        |=> REG_RDATA[15:8] == 8'h00)
        else $error("upper byte not zero");
    clear_needs_read_a: assert property (
        match_flag_reg && !match_armed_reg && csr_clear_req |=> match_flag_reg)
        else $error("flag cleared without read");
    force_high_a: assert property (
        parity_force_high_reg && !wr_par |=> PARITY_PIN_UPPER_OUT && PARITY_PIN_LOWER_OUT)
        else $error("parity pins not forced high");
    perr_set_a: assert property (
        MEM_XFER.rd_strobe && space_hit && lane_err[0] |=> parity_error_flag_reg)
        else $error("parity error not latched");

endmodule

// ===== test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic core_clk = 1'b0; // System clock, 40 ns
    logic nrst = 1'b0; // Power-on reset
    rfp_pkg::rfp_reg_req_type req = '0; // Register access
    rfp_pkg::rfp_mem_xfer_type xf = '0; // External transfer
    logic pu = 1'b0; // Received upper parity
    logic pl = 1'b0; // Received lower parity
    logic [15:0] rdata; // Read data
    logic irq, rreq, up_o, up_e, lo_o, lo_e; // Observed outputs
    logic sref; // Observed self-refresh level
    logic [1:0] rwait; // Observed refresh wait field
    int n_mismatch = 0; // Mismatches
    int check_count = 0; // Comparisons
    int cyc = 0; // Hang guard count
    int i, k, seen; // Loop helpers
    logic en, eu, el; // Expected parity pins
    logic [15:0] par_cfg [7] = '{16'h0000, 16'h0800, 16'h1000, 16'h1800, 16'h2800, 16'h4800,
                             16'h3000};
    int dv [7] = '{2, 8, 32, 128, 512, 2048, 4096};
    always #20 core_clk = ~core_clk;
    rfp_refresh_parity u_rfp_refresh_parity (.CORE_CLK(core_clk), .NRST(nrst),
        .REG_REQ(req), .REG_RDATA(rdata), .MATCH_INTERRUPT(irq), .REFRESH_REQ(rreq),
        .SELF_REFRESH(sref), .REFRESH_WAIT(rwait), .MEM_XFER(xf), .PARITY_PIN_UPPER_IN(pu),
        .PARITY_PIN_LOWER_IN(pl), .PARITY_PIN_UPPER_OUT(up_o), .PARITY_PIN_UPPER_OE(up_e),
        .PARITY_PIN_LOWER_OUT(lo_o), .PARITY_PIN_LOWER_OE(lo_e));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Hang guard; the slow divider scan dominates the run
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop();
        end
    end
    task automatic ck(input logic [15:0] a, input logic [15:0] e, input string m);
        check_count++;
        if (a !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h want %h", $time, m, a, e);
        end
    endtask
    // One register access; data is settled when this returns
    task automatic acc(input logic [2:0] s, input logic w, input logic wd16, input logic h,
                       input logic [15:0] d);
        @(posedge core_clk);
        req <= '{s, w, ~w, wd16, h, d};
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask
    task automatic rd_chk(input logic [2:0] s, input logic [15:0] e);
        acc(s, 1'b0, 1'b1, 1'b0, 16'h0000);
        ck(rdata, e, "register read");
    endtask
    task automatic wr_reg(input logic [2:0] s, input logic [15:0] d);
        acc(s, 1'b1, 1'b1, 1'b0, d);
    endtask
    // Checked DRAM read; lower pin level chosen by caller
    task automatic px(input logic l);
        @(posedge core_clk);
        xf <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0307};
        pl <= l;
        @(posedge core_clk);
        xf <= '0;
        #1;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        rd_chk(0, 16'h0000);
        rd_chk(1, 16'h0000);
        rd_chk(2, 16'h0000);
        rd_chk(3, 16'h00FF);
        rd_chk(4, 16'h0000);
        rd_chk(5, 16'h0000);
        acc(3, 1'b0, 1'b0, 1'b0, 16'h0000);
        ck(rdata, 16'h00FF, "byte read");
        $display("test reset done");
        // Keys: wrong ones and byte writes must bounce
        wr_reg(3, 16'h1210);
        acc(3, 1'b1, 1'b0, 1'b0, 16'h9605);
        rd_chk(3, 16'h00FF);
        wr_reg(3, 16'h9603);
        wr_reg(2, 16'h6901);
        wr_reg(0, 16'h5A80);
        wr_reg(1, 16'h5A48);
        repeat (6) @(posedge core_clk);
        rd_chk(2, 16'h0001);
        rd_chk(3, 16'h0003);
        rd_chk(0, 16'h0080);
        ck({13'h0, sref, rwait}, 16'h0000, "cbr mode outputs");
        rd_chk(1, 16'h0000);
        $display("test keys done");
        // Match with refresh and interrupt on, then flag clearing
        wr_reg(1, 16'hA548);
        seen = 0;
        for (i = 0; i < 40 && seen == 0; i++) begin
            @(negedge core_clk);
            seen = (rreq === 1'b1);
        end
        ck(16'(seen), 16'h0001, "refresh pulse");
        @(negedge core_clk);
        ck({15'h0, irq}, 16'h0001, "irq");
        wr_reg(1, 16'hA540);
        rd_chk(1, 16'h00C0);
        wr_reg(1, 16'hA540);
        rd_chk(1, 16'h0040);
        ck({15'h0, irq}, 16'h0000, "irq");
        // Refresh off: plain interval timer, no pulses
        wr_reg(0, 16'h5A70);
        ck({13'h0, sref, rwait}, 16'h0003, "refresh off outputs");
        wr_reg(1, 16'hA508);
        seen = 0;
        repeat (30) begin
            @(negedge core_clk);
            seen = seen + (rreq !== 1'b0);
        end
        ck(16'(seen), 16'h0000, "refresh off");
        rd_chk(1, 16'h0088);
        ck({15'h0, irq}, 16'h0000, "irq");
        wr_reg(0, 16'h5AC0);
        ck({13'h0, sref, rwait}, 16'h0004, "self refresh outputs");
        $display("test match done");
        // Divider scan; slow settings get a shorter window
        wr_reg(1, 16'hA500);
        wr_reg(3, 16'h96FF);
        for (i = 0; i < 7; i++) begin
            k = (i < 5) ? 20 : 2;
            wr_reg(2, 16'h6900);
            wr_reg(1, 16'hA500 | 16'((i + 1) << 3));
            repeat (k * dv[i] - 2) @(posedge core_clk);
            wr_reg(1, 16'hA500);
            acc(2, 1'b0, 1'b1, 1'b0, 16'h0000);
            ck(16'(rdata[7:0] >= k - 1 && rdata[7:0] <= k + 1), 16'h0001, "rate");
        end
        $display("test rate done");
        // Parity drive for every space, polarity and force setting
        for (i = 0; i < 7; i++) begin
            wr_reg(4, par_cfg[i]);
            for (k = 0; k < 2; k++) begin
                en = (par_cfg[i][12:11] == 2'h1) ? (k == 0) : (par_cfg[i][12:11] == 2'h2);
                eu = par_cfg[i][14] | par_cfg[i][13];
                el = par_cfg[i][14] | ~par_cfg[i][13];
                @(posedge core_clk);
                xf <= '{k == 0, k == 1, 1'b1, 1'b1, 1'b0, 16'h0307};
                @(posedge core_clk);
                xf <= '0;
                #1;
                ck({14'h0, up_e, lo_e}, {14'h0, en, en}, "parity oe");
                if (en) ck({14'h0, up_o, lo_o}, {14'h0, eu, el}, "parity out");
            end
        end
        // Error capture and read-then-write clearing
        wr_reg(4, 16'h0800);
        px(1'b1);
        rd_chk(4, 16'h0800);
        px(1'b0);
        wr_reg(4, 16'h0800);
        rd_chk(4, 16'h8800);
        wr_reg(4, 16'h0800);
        rd_chk(4, 16'h0800);
        $display("test parity done");
        report_and_stop();
    end
endmodule
